// ===== shot_pin_actuator.sv
// shot_pin_actuator: pin with extend and retract position switches.
// assumes level drives; jam keeps both switches from closing (stuck pin).
`timescale 1ns/1ns
module shot_pin_actuator #(
  parameter int NUM_GPI = 32,
  parameter int EXT_BIT = 5,
  parameter int RET_BIT = 17,
  parameter int TRAVEL  = 3
)(
  input  wire logic               clk,     // system clock
  input  wire logic               pin_ext, // extend drive
  input  wire logic               pin_ret, // retract drive
  input  wire logic               jam,     // pin stuck
  input  wire logic [NUM_GPI-1:0] noise,   // other inputs
  output logic      [NUM_GPI-1:0] gpi      // digital inputs
);
  int         run_q = 0;
  logic [1:0] drv_q = 2'h0;
  logic       ext_q = 1'b0;
  logic       ret_q = 1'b0;
  // travel restarts on any drive change; a switch opens as soon as the
  // pin is pushed the other way, so stale feedback never lingers
  always_ff @(posedge clk)
  begin
    drv_q <= {pin_ext, pin_ret};
    if ({pin_ext, pin_ret} != drv_q || pin_ext == pin_ret)
      run_q <= 0;
    else if (run_q < TRAVEL)
      run_q <= run_q + 1;
    ext_q <= !pin_ret && (ext_q || (pin_ext && !jam && run_q == TRAVEL));
    ret_q <= !pin_ext && (ret_q || (pin_ret && !jam && run_q == TRAVEL));
  end
  // unselected inputs carry a changing pattern
  always_comb
  begin
    gpi = noise;
    gpi[EXT_BIT] = ext_q;
    gpi[RET_BIT] = ret_q;
  end
endmodule : shot_pin_actuator

// ===== shot_pin_pkg.sv
// shot_pin_pkg: register map, field layout and timing constants for the
// shot pin sequencer; shared by the sequencer and its AXI4-Lite slave.
package shot_pin_pkg;

  // byte offsets of the control and status registers
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] SENSE_OFS    = 8'h04;
  localparam logic [7:0] EXT_TIME_OFS = 8'h08;
  localparam logic [7:0] RET_TIME_OFS = 8'h0C;
  localparam logic [7:0] CMD_OFS      = 8'h10;
  localparam logic [7:0] STAT_OFS     = 8'h14;

  // control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_TQ_LSB     = 1;
  localparam int CTRL_EXT_SNS    = 3;
  localparam int CTRL_RET_SNS    = 4;
  // sensor select fields
  localparam int SENSE_EXT_LSB   = 0;
  localparam int SENSE_RET_LSB   = 8;
  localparam int SEL_W           = 5;
  // command register fields (write one to act)
  localparam int CMD_EXT_BIT     = 0;
  localparam int CMD_RET_BIT     = 1;
  localparam int CMD_CLR_BIT     = 2;
  // time fields, in ticks of TICK_MS milliseconds
  localparam int TIME_W          = 16;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] TIME_RST  = 32'h0000_0064;

  // fixed time tick: 1 ms at the 10 MHz clock
  localparam int CLK_HZ          = 10_000_000;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYC        = CLK_HZ / 1000 * TICK_MS;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    TQ_NEVER  = 2'h0,
    TQ_BEFORE = 2'h1,
    TQ_AFTER  = 2'h2
  } torque_mode_t;

  typedef enum logic [2:0]
  {
    PIN_IDLE     = 3'h0,
    PIN_TQ_OFF   = 3'h1,
    PIN_EXTEND   = 3'h2,
    PIN_EXTENDED = 3'h3,
    PIN_RETRACT  = 3'h4,
    PIN_RETRACTED= 3'h5,
    PIN_ERROR    = 3'h6
  } pin_state_t;

endpackage : shot_pin_pkg

// ===== shot_pin_seq.sv
// shot_pin_seq: extend/retract state machine with tick timer.
// assumes configuration is held steady by software while moving.
`timescale 1ns/1ns
module shot_pin_seq #(
  parameter int NUM_GPI  = 32,
  parameter int TICK_CYC = shot_pin_pkg::TICK_CYC
)(
  input  wire logic                          clk,      // system clock
  input  wire logic                          sys_rst,  // sync reset
  input  wire logic                          enable,   // feature enable
  input  wire logic [1:0]                    tq_mode,  // torque mode
  input  wire logic                          ext_sns,  // extend sensor on
  input  wire logic                          ret_sns,  // retract sensor on
  input  wire logic [shot_pin_pkg::SEL_W-1:0] ext_sel, // extend gpi
  input  wire logic [shot_pin_pkg::SEL_W-1:0] ret_sel, // retract gpi
  input  wire logic [shot_pin_pkg::TIME_W-1:0] ext_time, // ticks
  input  wire logic [shot_pin_pkg::TIME_W-1:0] ret_time, // ticks
  input  wire logic [NUM_GPI-1:0]            gpi,      // digital inputs
  input  wire logic                          req_ext,  // extend pulse
  input  wire logic                          req_ret,  // retract pulse
  input  wire logic                          clr_err,  // clear error
  output logic                               pin_ext,  // extend drive
  output logic                               pin_ret,  // retract drive
  output logic                               torque_en,// axis torque
  output logic                               err_ext,  // extend timeout
  output logic                               err_ret,  // retract timeout
  output logic [2:0]                         state     // state code
);
  import shot_pin_pkg::*;

  pin_state_t              st_q, st_d;
  logic [TIME_W-1:0]       tmr_q;
  logic [$clog2(TICK_CYC)-1:0] pre_q;
  logic                    ext_err_q, ret_err_q;

  // feedback chosen from the gpi bank
  wire ext_fb  = gpi[ext_sel];
  wire ret_fb  = gpi[ret_sel];
  wire tick    = (pre_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));
  // a repeated request in the same direction restarts the travel time
  wire start   = ((st_d != st_q) &&
                  ((st_d == PIN_EXTEND) || (st_d == PIN_RETRACT) ||
                   (st_d == PIN_TQ_OFF))) ||
                 ((st_q == PIN_EXTEND) && go_ext) ||
                 ((st_q == PIN_RETRACT) && go_ret);
  wire ext_exp = (tmr_q >= ext_time);
  wire ret_exp = (tmr_q >= ret_time);
  wire go_ext  = enable && req_ext;
  wire go_ret  = enable && req_ret;

  // next state; a fresh request overrides one in progress
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      PIN_IDLE, PIN_RETRACTED, PIN_EXTENDED, PIN_ERROR:
      begin
        if (go_ext)
          st_d = (tq_mode == TQ_BEFORE) ? PIN_TQ_OFF : PIN_EXTEND;
        else if (go_ret)
          st_d = PIN_RETRACT;
      end
      PIN_TQ_OFF:
        if (go_ret)
          st_d = PIN_RETRACT;
        else
          st_d = PIN_EXTEND;          // torque dropped one cycle earlier
      PIN_EXTEND:
      begin
        if (go_ret)
          st_d = PIN_RETRACT;
        else if (ext_sns && ext_fb)
          st_d = PIN_EXTENDED;
        else if (ext_exp)
          st_d = ext_sns ? PIN_ERROR : PIN_EXTENDED;
      end
      PIN_RETRACT:
      begin
        if (go_ext)
          st_d = (tq_mode == TQ_BEFORE) ? PIN_TQ_OFF : PIN_EXTEND;
        else if (ret_sns && ret_fb)
          st_d = PIN_RETRACTED;
        else if (ret_exp)
          st_d = ret_sns ? PIN_ERROR : PIN_RETRACTED;
      end
      default:
        st_d = PIN_IDLE;
    endcase
  end

  // prescaled timer, restarted by every new command
  always_ff @(posedge clk)
  begin
    if (sys_rst || start)
    begin
      pre_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
      if (tick && (tmr_q != '1))
        tmr_q <= tmr_q + 1'b1;
    end
  end

  // error flags: a timeout wins over a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ext_err_q <= 1'b0;
      ret_err_q <= 1'b0;
    end
    else
    begin
      ext_err_q <= (st_q == PIN_EXTEND && st_d == PIN_ERROR) ||
                   (ext_err_q && !clr_err);
      ret_err_q <= (st_q == PIN_RETRACT && st_d == PIN_ERROR) ||
                   (ret_err_q && !clr_err);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_q <= PIN_IDLE;
    else
      st_q <= st_d;
  end

  // registered drives; torque is off while the pin holds the axis
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_ext   <= 1'b0;
      pin_ret   <= 1'b0;
      torque_en <= 1'b1;
    end
    else
    begin
      pin_ext   <= (st_d == PIN_EXTEND) || (st_d == PIN_EXTENDED);
      pin_ret   <= (st_d == PIN_RETRACT);
      torque_en <= !(((tq_mode == TQ_BEFORE) &&
                      ((st_d == PIN_TQ_OFF) || (st_d == PIN_EXTEND) ||
                       (st_d == PIN_EXTENDED))) ||
                     ((tq_mode == TQ_AFTER) && (st_d == PIN_EXTENDED)));
    end
  end

  assign err_ext = ext_err_q;
  assign err_ret = ret_err_q;
  assign state   = st_q;

endmodule : shot_pin_seq

// ===== shot_pin_sequencer.sv
// shot_pin_sequencer: AXI4-Lite register file around the shot pin sequencer.
// assumes gpi and axi inputs are synchronous to clk.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
module shot_pin_sequencer #(
  parameter int NUM_GPI  = 32,
  parameter int TICK_CYC = shot_pin_pkg::TICK_CYC
)(
  input  wire logic               clk,          // 10 MHz clock
  input  wire logic               sys_rst,      // sync reset, high
  input  wire logic [NUM_GPI-1:0] gpi,          // digital inputs
  input  wire logic               man_ext,      // manual extend pulse
  input  wire logic               man_ret,      // manual retract pulse
  output logic                    pin_ext,      // extend solenoid
  output logic                    pin_ret,      // retract solenoid
  output logic                    torque_en,    // axis torque allow
  input  wire logic [7:0]         s_axi_awaddr, // write address
  input  wire logic               s_axi_awvalid,// write addr valid
  output logic                    s_axi_awready,// write addr ready
  input  wire logic [31:0]        s_axi_wdata,  // write data
  input  wire logic [3:0]         s_axi_wstrb,  // byte strobes
  input  wire logic               s_axi_wvalid, // write data valid
  output logic                    s_axi_wready, // write data ready
  output logic [1:0]              s_axi_bresp,  // write response
  output logic                    s_axi_bvalid, // response valid
  input  wire logic               s_axi_bready, // response ready
  input  wire logic [7:0]         s_axi_araddr, // read address
  input  wire logic               s_axi_arvalid,// read addr valid
  output logic                    s_axi_arready,// read addr ready
  output logic [31:0]             s_axi_rdata,  // read data
  output logic [1:0]              s_axi_rresp,  // read response
  output logic                    s_axi_rvalid, // read valid
  input  wire logic               s_axi_rready  // read ready
);
  import shot_pin_pkg::*;

  // configuration registers
  logic [31:0] ctrl_q;    // enable, torque mode, sensor flags
  logic [31:0] sense_q;   // feedback input selects
  logic [31:0] ext_t_q;   // extend time, ticks
  logic [31:0] ret_t_q;   // retract time, ticks
  // write channel holding registers
  logic        aw_q;      // write address held
  logic        w_q;       // write data held
  logic [7:0]  awa_q;     // held write offset
  logic [31:0] wd_q;      // held write data
  logic [3:0]  ws_q;      // held byte strobes
  // command pulses towards the core
  logic        cext_q;    // extend request
  logic        cret_q;    // retract request
  logic        cclr_q;    // error clear
  // error flags sampled for status reads
  logic        sext_q;    // extend timeout seen
  logic        sret_q;    // retract timeout seen
  // core outputs
  logic        sq_ext;    // extend drive
  logic        sq_ret;    // retract drive
  logic        sq_tq;     // torque allow
  logic        sq_eext;   // extend error
  logic        sq_eret;   // retract error
  logic [2:0]  sq_state;  // core state code
  // read path
  logic [7:0]  ara_w;     // aligned read offset
  logic [31:0] rd_word;   // selected read word
  logic        rd_bad;    // unmapped read offset

  // aligned word offset; the low address bits never pick a register,
  // so a misaligned access lands on the word that holds it
  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction : word_ofs

  // byte-lane merge, used by each of the four configuration registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++)
      if (be[i])
        old[8*i +: 8] = nw[8*i +: 8];
    return old;
  endfunction : merge

  // write fires once both halves are held and no response is pending
  wire do_wr   = aw_q && w_q && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (awa_q == CTRL_OFS);
  wire wr_sns  = do_wr && (awa_q == SENSE_OFS);
  wire wr_et   = do_wr && (awa_q == EXT_TIME_OFS);
  wire wr_rt   = do_wr && (awa_q == RET_TIME_OFS);
  wire wr_cmd  = do_wr && (awa_q == CMD_OFS) && ws_q[0];
  wire wr_ok   = wr_ctrl || wr_sns || wr_et || wr_rt ||
                 (do_wr && (awa_q == CMD_OFS)) ||
                 (do_wr && (awa_q == STAT_OFS));
  wire do_rd   = s_axi_arvalid && s_axi_arready;

  // status word shows live drives, latched errors and state code;
  // the error bits lag the core by one cycle, harmless for software
  wire [31:0] stat_w = {24'h00_0000, sq_state, sret_q, sext_q,
                        sq_tq, sq_ret, sq_ext};

  // read selection; the command word reads zero, past status is slverr
  assign ara_w   = word_ofs(s_axi_araddr);
  assign rd_word = (ara_w == CTRL_OFS)     ? ctrl_q  :
                   (ara_w == SENSE_OFS)    ? sense_q :
                   (ara_w == EXT_TIME_OFS) ? ext_t_q :
                   (ara_w == RET_TIME_OFS) ? ret_t_q :
                   (ara_w == STAT_OFS)     ? stat_w  : 32'h0000_0000;
  assign rd_bad  = (ara_w > STAT_OFS);

  // write address half: held until the write fires
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_q  <= 1'b0;
      awa_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_q  <= 1'b1;
      awa_q <= word_ofs(s_axi_awaddr);
    end
    else if (do_wr)
      aw_q  <= 1'b0;
  end

  // write data half: may arrive before or after its address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      w_q  <= 1'b0;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_q  <= 1'b1;
      wd_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end
    else if (do_wr)
      w_q  <= 1'b0;
  end

  // address ready is high only while no address is held
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_axi_awready <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
      s_axi_awready <= 1'b0;
    else
      s_axi_awready <= !aw_q || do_wr;
  end

  // data ready mirrors it, so a second write waits for the first
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      s_axi_wready <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
      s_axi_wready <= 1'b0;
    else
      s_axi_wready <= !w_q || do_wr;
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_q  <= CTRL_RST;
      sense_q <= CTRL_RST;
      ext_t_q <= TIME_RST;
      ret_t_q <= TIME_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q  <= merge(ctrl_q, wd_q, ws_q);
      if (wr_sns)
        sense_q <= merge(sense_q, wd_q, ws_q);
      if (wr_et)
        ext_t_q <= merge(ext_t_q, wd_q, ws_q);
      if (wr_rt)
        ret_t_q <= merge(ret_t_q, wd_q, ws_q);
    end
  end

  // one-cycle command pulses, merged with the manual buttons
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cext_q <= 1'b0;
      cret_q <= 1'b0;
      cclr_q <= 1'b0;
    end
    else
    begin
      cext_q <= (wr_cmd && wd_q[CMD_EXT_BIT]) || man_ext;
      cret_q <= (wr_cmd && wd_q[CMD_RET_BIT]) || man_ret;
      cclr_q <= wr_cmd && wd_q[CMD_CLR_BIT];
    end
  end

  // read channel: one read at a time, answered one cycle after address
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !do_rd &&
                       !(s_axi_arready && !s_axi_arvalid);
      if (do_rd)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_bad ? RESP_SLVERR : RESP_OKAY;
        s_axi_rdata  <= rd_word;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // sequencer core
  shot_pin_seq #(
    .NUM_GPI  (NUM_GPI),
    .TICK_CYC (TICK_CYC)
  ) u_seq (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .enable    (ctrl_q[CTRL_EN_BIT]),
    .tq_mode   (ctrl_q[CTRL_TQ_LSB +: 2]),
    .ext_sns   (ctrl_q[CTRL_EXT_SNS]),
    .ret_sns   (ctrl_q[CTRL_RET_SNS]),
    .ext_sel   (sense_q[SENSE_EXT_LSB +: SEL_W]),
    .ret_sel   (sense_q[SENSE_RET_LSB +: SEL_W]),
    .ext_time  (ext_t_q[TIME_W-1:0]),
    .ret_time  (ret_t_q[TIME_W-1:0]),
    .gpi       (gpi),
    .req_ext   (cext_q),
    .req_ret   (cret_q),
    .clr_err   (cclr_q),
    .pin_ext   (sq_ext),
    .pin_ret   (sq_ret),
    .torque_en (sq_tq),
    .err_ext   (sq_eext),
    .err_ret   (sq_eret),
    .state     (sq_state)
  );

  // actuator outputs pass through the core's own flops
  assign pin_ext   = sq_ext;
  assign pin_ret   = sq_ret;
  assign torque_en = sq_tq;

  // status sampled for reads
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sext_q <= 1'b0;
      sret_q <= 1'b0;
    end
    else
    begin
      sext_q <= sq_eext;
      sret_q <= sq_eret;
    end
  end

endmodule : shot_pin_sequencer

// ===== shot_pin_sequencer_bench.sv
// shot_pin_sequencer_bench: register and pin sequencing tests.
// assumes a shortened tick of TC clocks and the actuator model.
`timescale 1ns/1ns
module shot_pin_sequencer_bench;
  import shot_pin_pkg::*;
  localparam int TC = 4;
  logic        clk, sys_rst, man_ext, man_ret, jam;
  logic [31:0] noise, gpi, wdata, rdata;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        pin_ext, pin_ret, torque_en, awready, wready;
  logic        bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bq[$], pq[$];
  logic [31:0] rq[$], mq[$];
  int          n_tests = 0;
  int          miscompares = 0;
  int          t;

  shot_pin_sequencer #(.TICK_CYC(TC)) shot_pin_sequencer_i (
    .clk(clk), .sys_rst(sys_rst), .gpi(gpi),
    .man_ext(man_ext), .man_ret(man_ret),
    .pin_ext(pin_ext), .pin_ret(pin_ret), .torque_en(torque_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  shot_pin_actuator shot_pin_actuator_i (
    .clk(clk), .pin_ext(pin_ext), .pin_ret(pin_ret), .jam(jam),
    .noise(noise), .gpi(gpi));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // every clock wait refreshes the noise on the spare inputs
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      noise <= $urandom;
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    bq.push_back(r);
    tick(1);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      tick(1);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back(e);
    mq.push_back(m);
    pq.push_back(r);
    tick(1);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      tick(1);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // one-cycle operator request, like a push button edge
  task automatic press(input logic ret);
    if (ret) man_ret <= 1'b1;
    else man_ext <= 1'b1;
    tick(1);
    man_ext <= 1'b0;
    man_ret <= 1'b0;
  endtask : press

  // answers are matched against the oldest note of the issuing task
  always @(posedge clk)
  begin
    if (bvalid && bready)
      chk({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready)
    begin
      chk({30'h0, rresp}, {30'h0, pq.pop_front()});
      chk(rdata & mq.pop_front(), rq.pop_front());
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the run is a few hundred cycles; this cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end

  initial
  begin
    {sys_rst, jam} = 2'h3;
    {man_ext, man_ret, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {noise, wdata, awaddr, araddr} = 80'h0;
    void'($urandom(32'h287C));
    tick(8);
    sys_rst <= 1'b0;
    tick(2);
    rd(CTRL_OFS, CTRL_RST);
    rd(EXT_TIME_OFS, TIME_RST);
    rd(RET_TIME_OFS, TIME_RST);
    rd(8'h18, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test registers done");
    wr(SENSE_OFS, 32'h0000_1105);
    wr(CMD_OFS, 32'h1);
    press(1'b0);
    tick(3);
    rd(STAT_OFS, 32'h04);
    $display("test disabled done");
    t = 3 + ($urandom % 4);
    wr(EXT_TIME_OFS, t);
    wr(RET_TIME_OFS, t);
    wr(CTRL_OFS, 32'h1);
    press(1'b0);
    rd(STAT_OFS, 32'h45);
    tick((t + 2) * TC + 8);
    rd(STAT_OFS, 32'h65);
    press(1'b1);
    rd(STAT_OFS, 32'h86);
    tick((t + 2) * TC + 8);
    rd(STAT_OFS, 32'hA4);
    $display("test timed travel done");
    jam <= 1'b0;
    wr(CTRL_OFS, 32'h1D);
    wr(EXT_TIME_OFS, 32'd20);
    wr(RET_TIME_OFS, 32'd20);
    wr(CMD_OFS, 32'h1);
    tick(20);
    rd(STAT_OFS, 32'h61);
    chk({29'h0, pin_ext, pin_ret, torque_en}, 32'h4);
    wr(CMD_OFS, 32'h2);
    tick(20);
    rd(STAT_OFS, 32'hA4);
    chk({29'h0, pin_ext, pin_ret, torque_en}, 32'h1);
    $display("test sensed travel done");
    jam <= 1'b1;
    wr(CTRL_OFS, 32'h1B);
    rd(CTRL_OFS, 32'h1B);
    wr(EXT_TIME_OFS, 32'd3);
    wr(CMD_OFS, 32'h1);
    tick(30);
    rd(STAT_OFS, 32'hC8, 32'hE8);
    wr(CMD_OFS, 32'h4);
    tick(3);
    rd(STAT_OFS, 32'h0, 32'h18);
    wr(RET_TIME_OFS, 32'd3);
    wr(CMD_OFS, 32'h2);
    tick(30);
    rd(STAT_OFS, 32'hD0, 32'hF0);
    $display("test timeouts done");
    tick(2);
    results();
  end
endmodule : shot_pin_sequencer_bench

bind shot_pin_sequencer shot_pin_sva shot_pin_sva_i (
  .clk(clk), .sys_rst(sys_rst), .pin_ext(pin_ext),
  .pin_ret(pin_ret), .torque_en(torque_en),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== shot_pin_sva.sv
// shot_pin_sva: checks on the drive outputs and the register bus.
// assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module shot_pin_sva (
  input wire logic        clk,           // system clock
  input wire logic        sys_rst,       // sync reset
  input wire logic        pin_ext,       // extend drive
  input wire logic        pin_ret,       // retract drive
  input wire logic        torque_en,     // axis torque
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic [1:0]  s_axi_bresp,   // write response
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready   // r ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // bus steps shared by the answer and hold checks
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  // outputs leave reset with the pin idle and torque allowed
  rst_outputs_a: assert property
    ($fell(sys_rst) |-> !pin_ext && !pin_ret && torque_en)
    else $error("drive outputs wrong after reset");
  // never push the pin both ways at once
  drive_excl_a: assert property
    (!(pin_ext && pin_ret))
    else $error("extend and retract driven together");
  // torque only drops just before or while the pin is extended
  torque_drop_a: assert property
    ($fell(torque_en) |-> ##[0:1] pin_ext)
    else $error("torque dropped without extend");
  // torque comes back only with the extend drive released
  torque_back_a: assert property
    ($rose(torque_en) |-> !pin_ext)
    else $error("torque restored while extending");
  b_answer_a: assert property
    (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property
    (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  r_answer_a: assert property
    (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  r_cause_a: assert property
    ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read data without request");
endmodule : shot_pin_sva
